// File: verilog/rtc_pkg.sv
// Purpose: Shared constants, layouts and types of the clock/calendar core.
// Assumes: 50 MHz system clock, 32.768 kHz time base made from it.
// Notes:   Byte offsets are the host bus addresses on the multiplexed bus.
package rtc_pkg;
    localparam int CLK_HZ          = 50_000_000;
    localparam int OSC_HZ          = 32_768;
    localparam int DIV_W           = 15;
    localparam int PHASE_W         = 27;
    localparam int START_DELAY_MS  = 500;
    localparam logic [DIV_W-1:0] START_LOAD = DIV_W'(OSC_HZ * START_DELAY_MS / 1000);
    // Pre-update window, rounded up to whole time-base ticks
    localparam int PRE_UPDATE_US    = 244;
    localparam int PRE_UPDATE_TICKS = (PRE_UPDATE_US * OSC_HZ + 999_999) / 1_000_000;
    localparam logic [DIV_W-1:0] PENDING_POINT = DIV_W'((2 ** DIV_W) - PRE_UPDATE_TICKS);
    // Length of the update cycle itself
    localparam int UPDATE_CYCLE_NS = 2000;
    localparam int UPDATE_CYCLES   = (UPDATE_CYCLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int UPD_CNT_W       = $clog2(UPDATE_CYCLES + 1);

    localparam logic [7:0] ADDR_SECONDS   = 8'h00;
    localparam logic [7:0] ADDR_SEC_MATCH = 8'h01;
    localparam logic [7:0] ADDR_MINUTES   = 8'h02;
    localparam logic [7:0] ADDR_MIN_MATCH = 8'h03;
    localparam logic [7:0] ADDR_HOURS     = 8'h04;
    localparam logic [7:0] ADDR_HR_MATCH  = 8'h05;
    localparam logic [7:0] ADDR_WEEKDAY   = 8'h06;
    localparam logic [7:0] ADDR_MONTHDAY  = 8'h07;
    localparam logic [7:0] ADDR_MONTH     = 8'h08;
    localparam logic [7:0] ADDR_YEAR      = 8'h09;
    localparam logic [7:0] ADDR_RATE      = 8'h0A;
    localparam logic [7:0] ADDR_CONTROL   = 8'h0B;
    localparam logic [7:0] ADDR_STATUS    = 8'h0C;
    localparam logic [7:0] ADDR_VALID     = 8'h0D;

    localparam int CTL_FREEZE = 7;
    localparam int CTL_PIE    = 6;
    localparam int CTL_AIE    = 5;
    localparam int CTL_UIE    = 4;
    localparam int CTL_SQE    = 3;
    localparam int CTL_BIN    = 2;
    localparam int CTL_H24    = 1;
    localparam int OSC_LSB    = 4;
    localparam logic [2:0] OSC_RUN_DIV = 3'h2;
    localparam logic [1:0] OSC_HOLD    = 2'h3;
    localparam logic [1:0] MATCH_ANY   = 2'h3;

    localparam logic [6:0] RATE_RESET    = 7'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h02;
    localparam logic [7:0] VALID_READ    = 8'h80;
    localparam logic [7:0] MATCH_RESET   = 8'h00;

    typedef struct packed {
        logic       cs_n;
        logic       addr_strobe;
        logic       data_strobe;
        logic       read_not_write;
        logic [7:0] ad;
    } host_bus_s;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] monthday;
        logic [7:0] weekday;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } clock_time_s;

    localparam clock_time_s TIME_RESET = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};

    typedef enum logic {UPD_IDLE, UPD_BUSY} upd_state_e;
endpackage

// File: verilog/rtc_timebase.sv
// Purpose: Time base, one-second divider and rate tap multiplexer.
// Assumes: Fractional phase accumulator gives an exact average 32.768 kHz.
// Notes:   Tick jitter is one system clock, invisible at these rates.
`timescale 1ns/10ps
module rtc_timebase #(
    parameter int DIV_W = rtc_pkg::DIV_W
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             osc_run,
    input  wire logic             div_run,
    input  wire logic             div_load,
    input  wire logic [3:0]       rate_select,
    output logic                  osc_tick,
    output logic                  second_tick,
    output logic                  tap_level,
    output logic                  tap_fall,
    output logic [DIV_W-1:0]      div_count
);
    import rtc_pkg::*;

    logic [PHASE_W-1:0] phase;
    logic [PHASE_W-1:0] next_phase;
    logic [PHASE_W-1:0] sum;
    logic [DIV_W-1:0]   next_div;
    logic               tap_prev;
    logic               next_tap_prev;
    logic [3:0]         tap_index;

    always_comb begin
        sum      = phase + PHASE_W'(OSC_HZ);
        osc_tick = osc_run && (sum >= PHASE_W'(CLK_HZ));
        if (!osc_run) begin
            next_phase = '0;
        end else if (osc_tick) begin
            next_phase = sum - PHASE_W'(CLK_HZ);
        end else begin
            next_phase = sum;
        end
        // Load wins so a fresh start is not lost to the old run state
        if (div_load) begin
            next_div = START_LOAD;
        end else if (!div_run) begin
            next_div = '0;
        end else if (osc_tick) begin
            next_div = div_count + 1'b1;
        end else begin
            next_div = div_count;
        end
        second_tick = osc_tick && div_run && !div_load && (&div_count);
        // Codes 1 and 2 reuse the 256 Hz and 128 Hz taps
        tap_index = (rate_select >= 4'h3) ? rate_select - 4'h2 : rate_select + 4'h5;
        tap_level = (rate_select != 4'h0) && div_count[tap_index];
        tap_fall      = tap_prev && !tap_level;
        next_tap_prev = tap_level;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase     <= '0;
            div_count <= '0;
            tap_prev  <= 1'b0;
        end else begin
            phase     <= next_phase;
            div_count <= next_div;
            tap_prev  <= next_tap_prev;
        end
    end
endmodule

// File: verilog/rtc_core.sv
// Purpose: Clock/calendar core with alarm, rate output and event flags.
// Assumes: Host bus strobes are synchronous to sys_clk, bus timing strobe style.
// Notes:   Interrupt pin is open drain, driven low only through irq_oe.
`timescale 1ns/10ps
module rtc_core (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire rtc_pkg::host_bus_s bus_in,
    output logic [7:0]              ad_out,
    output logic                    ad_oe,
    output logic                    irq_n_out,
    output logic                    irq_oe,
    output logic                    square_out
);
    import rtc_pkg::*;

    function automatic logic [6:0] from_fmt(input logic [7:0] v, input logic bin);
        if (bin) begin
            return v[6:0];
        end
        return {3'h0, v[7:4]} * 7'h0A + {3'h0, v[3:0]};
    endfunction

    function automatic logic [7:0] to_fmt(input logic [6:0] n, input logic bin);
        if (bin) begin
            return {1'b0, n};
        end
        return {4'(n / 7'h0A), 4'(n % 7'h0A)};
    endfunction

    function automatic logic [6:0] hour_to_24(input logic [7:0] v, input logic bin, input logic h24);
        logic [6:0] raw;
        raw = from_fmt({1'b0, v[6:0]}, bin);
        if (h24) begin
            return from_fmt(v, bin);
        end
        return ((raw == 7'h0C) ? 7'h00 : raw) + (v[7] ? 7'h0C : 7'h00);
    endfunction

    function automatic logic [7:0] hour_from_24(input logic [6:0] h, input logic bin, input logic h24);
        logic [6:0] r;
        logic [7:0] f;
        r = (h >= 7'h0C) ? h - 7'h0C : h;
        if (r == 7'h00) begin
            r = 7'h0C;
        end
        f = to_fmt(r, bin);
        if (h24) begin
            return to_fmt(h, bin);
        end
        return {h >= 7'h0C, f[6:0]};
    endfunction

    function automatic logic [6:0] month_days(input logic [6:0] mo, input logic [6:0] yr);
        unique case (mo)
            7'h02: return (yr[1:0] == 2'h0) ? 7'h1D : 7'h1C;
            7'h04, 7'h06, 7'h09, 7'h0B: return 7'h1E;
            default: return 7'h1F;
        endcase
    endfunction

    function automatic logic byte_match(input logic [7:0] want, input logic [7:0] have);
        return (want[7:6] == MATCH_ANY) || (want == have);
    endfunction

    logic                 as_prev, ds_prev, next_as_prev, next_ds_prev;
    logic [7:0]           addr, next_addr, rd_data, next_rd_data;
    logic                 wr_strobe, rd_done;
    logic [6:0]           rate, next_rate;
    logic [7:0]           control, next_control;
    logic                 div_load, osc_run, div_run, freeze, bin, h24;
    clock_time_s          local_time, buffer_time, stepped, next_local, next_buffer;
    logic [7:0]           sec_match, min_match, hr_match;
    logic [7:0]           next_sec_match, next_min_match, next_hr_match;
    logic                 alarm_hit, update_end, pending, next_pending;
    upd_state_e           state, next_state;
    logic [UPD_CNT_W-1:0] busy_count, next_busy_count;
    logic [2:0]           flags, next_flags, irq_en;
    logic                 irq_summary_flag, next_irq_summary_flag, status_clear, next_square;
    logic                 osc_tick, second_tick, tap_level, tap_fall;
    logic [DIV_W-1:0]     div_count;

    assign freeze  = control[CTL_FREEZE];
    assign bin     = control[CTL_BIN];
    assign h24     = control[CTL_H24];
    assign osc_run = (rate[6:4] == OSC_RUN_DIV) || (rate[6:5] == OSC_HOLD);
    assign div_run = (rate[6:4] == OSC_RUN_DIV);

    rtc_timebase #(
        .DIV_W       (DIV_W)
    ) u_timebase (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .osc_run     (osc_run),
        .div_run     (div_run),
        .div_load    (div_load),
        .rate_select (rate[3:0]),
        .osc_tick    (osc_tick),
        .second_tick (second_tick),
        .tap_level   (tap_level),
        .tap_fall    (tap_fall),
        .div_count   (div_count)
    );

    // Host bus: address on strobe fall, write on data strobe fall
    always_comb begin
        next_as_prev = bus_in.addr_strobe;
        next_ds_prev = bus_in.data_strobe;
        next_addr    = (as_prev && !bus_in.addr_strobe) ? bus_in.ad : addr;
        wr_strobe    = ds_prev && !bus_in.data_strobe && !bus_in.cs_n && !bus_in.read_not_write;
        rd_done      = ds_prev && !bus_in.data_strobe && !bus_in.cs_n && bus_in.read_not_write;
        ad_oe        = !bus_in.cs_n && bus_in.data_strobe && bus_in.read_not_write;
        unique case (addr)
            ADDR_SECONDS:   next_rd_data = buffer_time.seconds;
            ADDR_SEC_MATCH: next_rd_data = sec_match;
            ADDR_MINUTES:   next_rd_data = buffer_time.minutes;
            ADDR_MIN_MATCH: next_rd_data = min_match;
            ADDR_HOURS:     next_rd_data = buffer_time.hours;
            ADDR_HR_MATCH:  next_rd_data = hr_match;
            ADDR_WEEKDAY:   next_rd_data = buffer_time.weekday;
            ADDR_MONTHDAY:  next_rd_data = buffer_time.monthday;
            ADDR_MONTH:     next_rd_data = buffer_time.month;
            ADDR_YEAR:      next_rd_data = buffer_time.year;
            ADDR_RATE:      next_rd_data = {pending, rate};
            ADDR_CONTROL:   next_rd_data = control;
            ADDR_STATUS:    next_rd_data = {irq_summary_flag, flags, 4'h0};
            ADDR_VALID:     next_rd_data = VALID_READ;
            default:        next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            as_prev <= 1'b0;
            ds_prev <= 1'b0;
            addr    <= 8'h00;
            rd_data <= 8'h00;
        end else begin
            as_prev <= next_as_prev;
            ds_prev <= next_ds_prev;
            addr    <= next_addr;
            rd_data <= next_rd_data;
        end
    end
    assign ad_out = rd_data;

    // Control registers; pending bit is hardware owned and not writable
    always_comb begin
        next_rate    = rate;
        next_control = control;
        div_load     = 1'b0;
        if (wr_strobe && addr == ADDR_RATE) begin
            next_rate = bus_in.ad[6:0];
            div_load  = (bus_in.ad[6:4] == OSC_RUN_DIV) && !div_run;
        end
        if (wr_strobe && addr == ADDR_CONTROL) begin
            next_control          = bus_in.ad;
            next_control[CTL_UIE] = bus_in.ad[CTL_UIE] && !bus_in.ad[CTL_FREEZE];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rate    <= RATE_RESET;
            control <= CONTROL_RESET;
        end else begin
            rate    <= next_rate;
            control <= next_control;
        end
    end

    // One-step calendar advance of the local copy
    always_comb begin
        logic [6:0] s, m, h, wd, md, mo, yr, mlen;
        s    = from_fmt(local_time.seconds, bin) + 7'h01;
        m    = from_fmt(local_time.minutes, bin);
        h    = hour_to_24(local_time.hours, bin, h24);
        wd   = from_fmt(local_time.weekday, bin);
        md   = from_fmt(local_time.monthday, bin);
        mo   = from_fmt(local_time.month, bin);
        yr   = from_fmt(local_time.year, bin);
        mlen = month_days(mo, yr);
        if (s >= 7'h3C) begin
            s = 7'h00;
            m = m + 7'h01;
            if (m >= 7'h3C) begin
                m = 7'h00;
                h = h + 7'h01;
                if (h >= 7'h18) begin
                    h  = 7'h00;
                    wd = (wd >= 7'h07) ? 7'h01 : wd + 7'h01;
                    md = md + 7'h01;
                    if (md > mlen) begin
                        md = 7'h01;
                        mo = mo + 7'h01;
                        if (mo > 7'h0C) begin
                            mo = 7'h01;
                            yr = (yr >= 7'h63) ? 7'h00 : yr + 7'h01;
                        end
                    end
                end
            end
        end
        stepped.seconds  = to_fmt(s, bin);
        stepped.minutes  = to_fmt(m, bin);
        stepped.hours    = hour_from_24(h, bin, h24);
        stepped.weekday  = to_fmt(wd, bin);
        stepped.monthday = to_fmt(md, bin);
        stepped.month    = to_fmt(mo, bin);
        stepped.year     = to_fmt(yr, bin);
        alarm_hit = byte_match(sec_match, stepped.seconds)
                 && byte_match(min_match, stepped.minutes)
                 && byte_match(hr_match, stepped.hours);
    end

    // Update cycle sequencing
    always_comb begin
        next_state      = state;
        next_busy_count = busy_count;
        update_end      = 1'b0;
        unique case (state)
            UPD_IDLE: begin
                if (second_tick) begin
                    next_state      = UPD_BUSY;
                    next_busy_count = '0;
                end
            end
            UPD_BUSY: begin
                next_busy_count = busy_count + 1'b1;
                if (busy_count == UPD_CNT_W'(UPDATE_CYCLES - 1)) begin
                    update_end = 1'b1;
                    next_state = UPD_IDLE;
                end
            end
        endcase
        if (freeze || update_end) begin
            next_pending = 1'b0;
        end else if (osc_tick && div_run && div_count == PENDING_POINT) begin
            next_pending = 1'b1;
        end else begin
            next_pending = pending;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state      <= UPD_IDLE;
            busy_count <= '0;
            pending    <= 1'b0;
        end else begin
            state      <= next_state;
            busy_count <= next_busy_count;
            pending    <= next_pending;
        end
    end

    // Time copies; host writes land in both so a new setting takes hold
    always_comb begin
        next_local     = update_end ? stepped : local_time;
        next_buffer    = (update_end && !freeze) ? stepped : buffer_time;
        next_sec_match = sec_match;
        next_min_match = min_match;
        next_hr_match  = hr_match;
        if (wr_strobe) begin
            unique case (addr)
                ADDR_SECONDS:   next_local.seconds  = bus_in.ad;
                ADDR_MINUTES:   next_local.minutes  = bus_in.ad;
                ADDR_HOURS:     next_local.hours    = bus_in.ad;
                ADDR_WEEKDAY:   next_local.weekday  = bus_in.ad;
                ADDR_MONTHDAY:  next_local.monthday = bus_in.ad;
                ADDR_MONTH:     next_local.month    = bus_in.ad;
                ADDR_YEAR:      next_local.year     = bus_in.ad;
                ADDR_SEC_MATCH: next_sec_match = bus_in.ad;
                ADDR_MIN_MATCH: next_min_match = bus_in.ad;
                ADDR_HR_MATCH:  next_hr_match  = bus_in.ad;
                default: begin
                end
            endcase
            unique case (addr)
                ADDR_SECONDS:   next_buffer.seconds  = bus_in.ad;
                ADDR_MINUTES:   next_buffer.minutes  = bus_in.ad;
                ADDR_HOURS:     next_buffer.hours    = bus_in.ad;
                ADDR_WEEKDAY:   next_buffer.weekday  = bus_in.ad;
                ADDR_MONTHDAY:  next_buffer.monthday = bus_in.ad;
                ADDR_MONTH:     next_buffer.month    = bus_in.ad;
                ADDR_YEAR:      next_buffer.year     = bus_in.ad;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            local_time  <= TIME_RESET;
            buffer_time <= TIME_RESET;
            sec_match   <= MATCH_RESET;
            min_match   <= MATCH_RESET;
            hr_match    <= MATCH_RESET;
        end else begin
            local_time  <= next_local;
            buffer_time <= next_buffer;
            sec_match   <= next_sec_match;
            min_match   <= next_min_match;
            hr_match    <= next_hr_match;
        end
    end

    // Event flags {periodic, alarm, done}; a new event beats a clearing read
    always_comb begin
        status_clear = rd_done && addr == ADDR_STATUS;
        irq_en       = {control[CTL_PIE], control[CTL_AIE], control[CTL_UIE] && !freeze};
        next_flags   = (flags & {3{!status_clear}})
                     | {tap_fall, update_end && alarm_hit, update_end};
        next_irq_summary_flag    = (irq_summary_flag && !status_clear) || (|(next_flags & irq_en));
        irq_oe       = |(flags & irq_en);
        next_square  = tap_level && control[CTL_SQE];
    end
    assign irq_n_out = 1'b0;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flags      <= 3'h0;
            irq_summary_flag       <= 1'b0;
            square_out <= 1'b0;
        end else begin
            flags      <= next_flags;
            irq_summary_flag       <= next_irq_summary_flag;
            square_out <= next_square;
        end
    end
endmodule

// File: bench/rtc_core_properties.sv
// Purpose: Port checks of the clock core.
// Assumes: Shadows of rate and control follow host writes at the design's edge.
// Notes:   Reads are judged only once data strobe has stood two edges.
`timescale 1ns/10ps
module rtc_core_properties (
    input wire logic               sys_clk,
    input wire logic               rst,
    input wire rtc_pkg::host_bus_s bus_in,
    input wire logic [7:0]         ad_out,
    input wire logic               ad_oe,
    input wire logic               irq_n_out,
    input wire logic               irq_oe,
    input wire logic               square_out
);
    import rtc_pkg::*;
    logic [7:0] adr;
    logic [7:0] ctl;
    logic [6:0] rte;
    logic       ds_q;
    logic       as_q;
    logic       rd_ok;
    assign rd_ok = ds_q && bus_in.data_strobe && bus_in.read_not_write && !bus_in.cs_n;
    always_ff @(posedge sys_clk) begin
        ds_q <= bus_in.data_strobe;
        as_q <= bus_in.addr_strobe;
        if (as_q && !bus_in.addr_strobe) adr <= bus_in.ad;
        if (rst) begin
            ctl <= CONTROL_RESET;
            rte <= RATE_RESET;
        end else if (ds_q && !bus_in.data_strobe && !bus_in.cs_n && !bus_in.read_not_write) begin
            if (adr == ADDR_CONTROL) ctl <= bus_in.ad[7] ? (bus_in.ad & 8'hEF) : bus_in.ad;
            if (adr == ADDR_RATE) rte <= bus_in.ad[6:0];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_irq_pin_low: assert property (irq_n_out == 1'b0) else $error("irq pin value not low");
    a_irq_release_read: assert property ($fell(irq_oe) |-> !ds_q && $past(ds_q))
        else $error("irq released without host access");
    a_irq_needs_enable: assert property (ctl[6:4] == 3'h0 |-> !irq_oe) else $error("irq without enable");
    a_square_held_low: assert property (!ctl[CTL_SQE] && !$past(ctl[CTL_SQE]) |-> !square_out)
        else $error("square out while disabled");
    a_square_no_rate: assert property (rte[3:0] == 4'h0 && $past(rte[3:0]) == 4'h0 |-> !square_out)
        else $error("square out with rate off");
    a_freeze_clears_uie: assert property (rd_ok && adr == ADDR_CONTROL && ctl[7] |-> !ad_out[CTL_UIE])
        else $error("update enable kept under freeze");
    a_freeze_no_pending: assert property (rd_ok && adr == ADDR_RATE && ctl[7] |-> !ad_out[7])
        else $error("pending set under freeze");
    a_rate_read_back: assert property (rd_ok && adr == ADDR_RATE |-> ad_out[6:0] == rte)
        else $error("rate byte read wrong");
    c_irq_release: cover property ($fell(irq_oe));
    c_square_run: cover property ($rose(square_out));
    c_freeze_rate: cover property (rd_ok && adr == ADDR_RATE && ctl[7]);
endmodule
bind rtc_core rtc_core_properties rtc_core_properties_i (.sys_clk(sys_clk), .rst(rst), .bus_in(bus_in),
    .ad_out(ad_out), .ad_oe(ad_oe), .irq_n_out(irq_n_out), .irq_oe(irq_oe), .square_out(square_out));

// File: bench/rtc_host_model.sv
// Purpose: Host side of the multiplexed address/data bus.
// Assumes: One whole bus cycle per call, started after a clock edge.
// Notes:   A released ad shows the inverse of the last byte.
`timescale 1ns/10ps
module rtc_host_model (
    input  wire logic          sys_clk,
    input  wire logic [7:0]    ad_out,
    input  wire logic          ad_oe,
    output rtc_pkg::host_bus_s bus
);
    import rtc_pkg::*;
    host_bus_s hb = '{1'b1, 1'b0, 1'b0, 1'b1, 8'h00};
    assign bus = '{hb.cs_n, hb.addr_strobe, hb.data_strobe, hb.read_not_write, ad_oe ? ad_out : hb.ad};
    // Caller keeps reads away from update cycles
    task automatic cyc(input logic [7:0] a, input logic [7:0] d, input logic rw, output logic [7:0] q);
        @(posedge sys_clk) hb.addr_strobe <= 1'b1;
        hb.ad <= a;
        @(posedge sys_clk) hb.addr_strobe <= 1'b0;
        @(posedge sys_clk) hb.cs_n <= 1'b0;
        hb.read_not_write <= rw;
        hb.data_strobe <= 1'b1;
        hb.ad <= rw ? ~a : d;
        repeat (2) @(posedge sys_clk);
        // Taken off the shared bus so a missing drive enable shows up
        q = bus.ad;
        hb.data_strobe <= 1'b0;
        @(posedge sys_clk) hb.cs_n <= 1'b1;
        hb.ad <= ~hb.ad;
    endtask
endmodule

// File: bench/rtc_core_tb_top.sv
// Purpose: Self-checking bench of the clock core.
// Assumes: Whole seconds are out of reach; fast rate taps stand in.
// Notes:   Reference keeps host-visible bytes in an int array.
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
    checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("Error %0s exp %h got %h", n, e, g); \
    end \
end
module rtc_core_tb_top;
    import rtc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    host_bus_s   bus_in;
    logic [7:0]  ad_out, q, d;
    logic        ad_oe, irq_n_out, irq_oe, square_out;
    int          err_total = 0, checks = 0;
    int          mem[14] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 0, 0, 2, 0, 8'h80};
    int          lim[10] = '{60, 60, 60, 60, 12, 12, 7, 31, 12, 100};
    int          bas[10] = '{0, 0, 0, 0, 1, 1, 1, 1, 1, 0};
    logic [31:0] rnd = 32'hFFC17B5C;
    rtc_core rtc_core_i (.sys_clk(sys_clk), .rst(rst), .bus_in(bus_in), .ad_out(ad_out), .ad_oe(ad_oe),
        .irq_n_out(irq_n_out), .irq_oe(irq_oe), .square_out(square_out));
    rtc_host_model rtc_host_model_i (.sys_clk(sys_clk), .ad_out(ad_out), .ad_oe(ad_oe), .bus(bus_in));
    initial forever #10 sys_clk = ~sys_clk;
    task automatic end_of_test();
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(input int a, input int v);
        rtc_host_model_i.cyc(a[7:0], v[7:0], 1'b0, q);
        if (a < 10) mem[a] = v;
        if (a == ADDR_RATE) mem[a] = v & 8'h7F;
        if (a == ADDR_CONTROL) mem[a] = v[7] ? v & 8'hEF : v;
    endtask
    task automatic rd(input int a, input int e);
        rtc_host_model_i.cyc(a[7:0], 8'h00, 1'b1, q);
        `CHK($sformatf("reg_%h", a), e[7:0], q)
    endtask
    task automatic rd_all();
        for (int a = 0; a < 14; a++) rd(a, mem[a]);
    endtask
    // Bounded wait for irq (sel 0) or square wave (sel 1) going high
    task automatic wait_for(input int sel, input int lim_c);
        int i;
        for (i = 0; i < lim_c && (sel ? square_out : irq_oe) !== 1'b1; i++) @(posedge sys_clk);
        if (i == lim_c) begin
            err_total++;
            end_of_test();
        end
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd_all();
        wr(ADDR_CONTROL, 8'h90);
        rd(ADDR_CONTROL, 8'h80);
        rd(ADDR_RATE, 8'h00);
        wr(ADDR_CONTROL, 8'h84);
        for (int a = 0; a < 10; a++) begin
            rnd = lfsr(rnd);
            d = 8'(int'(rnd[15:0]) % lim[a] + bas[a]);
            if (a == 4 || a == 5) d[7] = rnd[20];
            wr(a, d);
        end
        wr(ADDR_CONTROL, 8'h04);
        rd_all();
        // Oscillator on but divider held: no periodic taps move
        wr(ADDR_RATE, 8'h63);
        repeat (12500) @(posedge sys_clk);
        rd(ADDR_STATUS, 8'h00);
        wr(ADDR_RATE, 8'h23);
        repeat (12500) @(posedge sys_clk);
        // Flag already stands here, but no request without its enable
        `CHK("irq_oe", 1'b0, irq_oe)
        rd(ADDR_STATUS, 8'h40);
        wr(ADDR_CONTROL, 8'h4C);
        wait_for(0, 7000);
        rd(ADDR_STATUS, 8'hC0);
        @(posedge sys_clk);
        `CHK("irq_oe", 1'b0, irq_oe)
        wait_for(1, 7000);
        wr(ADDR_RATE, 8'h20);
        repeat (7000) @(posedge sys_clk);
        `CHK("square_out", 1'b0, square_out)
        end_of_test();
    end
endmodule
